// [src/tpw_ctrl.sv]
// Operation
// [RL1] enable bit starts and stops each channel
// [RL2] registers and queue writable while channels disabled
// [RL3] mode bit: zero modulation, one serial
// [RL4] serial word sent MSB first, cut or padded
// [RL5] mark/space select, ignored in serial mode
// [RL6] repeat resends last queue word when empty
// [RL7] idle level drives output between and after transfers
// [RL8] polarity bit inverts final channel output
// [RL9] source select picks queue or value register
// [RL10] queue clear writes empty queue, reads zero
// [RL11] full bit 0, empty bit 1 flags
// [RL12] overwrite error on full write, write-one clears
// [RL13] underread error on empty read, write-one clears
// [RL14] gap flag when queue channel starves, not repeating
// [RL15] bus error on too-fast same-register writes
// [RL16] active bit shows channel transmitting
// [RL17] software writes zero to reserved control bits
// [RL18] spread mode accumulates value, emits one on overflow
// [RL19] mark/space: value is mark, period whole length
// [RL20] period resets to 32, sets serial length
// [RL21] shared queue holds eight 32-bit words
// [RL22] mark/space drives mark then idle, repeating; code drives low after the mark whatever the idle bit
`timescale 1ns/100ps
`default_nettype none
module tpw_ctrl
  import tpw_pkg::*;
#(
  parameter int QUEUE_DEPTH = 8
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // peripheral bus slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // modulated outputs and dma config
  output logic [1:0]       chan_out_o,
  output logic [31:0]      dma_config_o
);
  import tpw_pkg::*;

  localparam int PW = $clog2(QUEUE_DEPTH);

  typedef struct packed {
    logic [15:0]                  ctl;
    logic [31:0]                  dma_config;
    logic [1:0][31:0]             period;
    logic [1:0][31:0]             value;
    logic [QUEUE_DEPTH-1:0][31:0] mem;
    logic [PW-1:0]                wptr;
    logic [PW-1:0]                rptr;
    logic [PW:0]                  count;
    logic                         werr;
    logic                         rerr;
    logic                         bus_sync_error;
    logic [1:0]                   gap;
    logic [1:0]                   active;
    logic [1:0]                   have_last;
    logic [1:0][31:0]             acc;
    logic [1:0][31:0]             pos;
    logic [1:0][31:0]             word;
    logic [1:0]                   out;
    logic [31:0]                  rdata;
    logic                         rerr_bus;
    logic [7:0]                   last_waddr;
    logic [1:0]                   waddr_age;
  } tpw_state_type;

  tpw_state_type s_q;
  tpw_state_type s_d;

  function automatic logic [31:0] read_word(input tpw_state_type s,
                                            input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      TPW_OFS_CHANNEL_CONTROL: r = {16'h0000, s.ctl};
      TPW_OFS_FLAGS: begin
        r[TPW_STA_FULL]          = (s.count == (PW+1)'(QUEUE_DEPTH)); // RL11
        r[TPW_STA_EMPTY]         = (s.count == '0); // RL11
        r[TPW_STA_WERR]          = s.werr;
        r[TPW_STA_RERR]          = s.rerr;
        r[TPW_STA_GAP +: 2]      = s.gap;
        r[TPW_STA_BUS_SYNC_ERROR]          = s.bus_sync_error;
        r[TPW_STA_ACTIVE +: 2]   = s.active; // RL16
      end
      TPW_OFS_DMA_CONFIG:      r = s.dma_config;
      TPW_OFS_CHANNEL1_PERIOD: r = s.period[0];
      TPW_OFS_CHANNEL1_VALUE:  r = s.value[0];
      TPW_OFS_CHANNEL2_PERIOD: r = s.period[1];
      TPW_OFS_CHANNEL2_VALUE:  r = s.value[1];
      default:                 r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    logic m;
    m = 1'b0;
    case (a)
      TPW_OFS_CHANNEL_CONTROL, TPW_OFS_FLAGS, TPW_OFS_DMA_CONFIG,
      TPW_OFS_CHANNEL1_PERIOD, TPW_OFS_CHANNEL1_VALUE,
      TPW_OFS_QUEUE_INPUT, TPW_OFS_CHANNEL2_PERIOD,
      TPW_OFS_CHANNEL2_VALUE: m = 1'b1;
      default: m = 1'b0;
    endcase
    return m;
  endfunction

  always_comb begin
    logic        wr;
    logic        en;
    logic        ser;
    logic        rpt;
    logic        idl;
    logic        inv;
    logic        qsrc;
    logic        ms;
    logic        have;
    logic        bitv;
    logic [31:0] p;
    logic [31:0] w;
    logic [32:0] sum;
    logic [PW-1:0] rp;
    logic [PW:0]   cnt;
    logic [1:0]  gap_set;
    logic        rerr_set;
    logic        werr_set;
    logic        bus_sync_error_set;
    s_d      = s_q;
    wr       = psel_i & penable_i & pwrite_i;
    en       = 1'b0;
    ser      = 1'b0;
    rpt      = 1'b0;
    idl      = 1'b0;
    inv      = 1'b0;
    qsrc     = 1'b0;
    ms       = 1'b0;
    have     = 1'b0;
    bitv     = 1'b0;
    p        = 32'h0000_0000;
    w        = 32'h0000_0000;
    sum      = 33'h0_0000_0000;
    rp       = s_q.rptr;
    cnt      = s_q.count;
    gap_set  = 2'h0;
    rerr_set = 1'b0;
    werr_set = 1'b0;
    bus_sync_error_set = 1'b0;

    // channel engines draw from the queue in turn
    for (int i = 0; i < 2; i++) begin
      en   = s_q.ctl[i*TPW_CTL_STRIDE + TPW_CTL_ENABLE];
      ser  = s_q.ctl[i*TPW_CTL_STRIDE + TPW_CTL_SERIAL];
      rpt  = s_q.ctl[i*TPW_CTL_STRIDE + TPW_CTL_REPEAT];
      idl  = s_q.ctl[i*TPW_CTL_STRIDE + TPW_CTL_IDLE];
      inv  = s_q.ctl[i*TPW_CTL_STRIDE + TPW_CTL_INVERT];
      qsrc = s_q.ctl[i*TPW_CTL_STRIDE + TPW_CTL_QUEUE_SRC];
      ms   = s_q.ctl[i*TPW_CTL_STRIDE + TPW_CTL_MARK_SPACE];
      p    = s_q.period[i];
      w    = s_q.word[i];
      have = s_q.active[i];
      if (!en) begin
        // disabled: engine parked, state cleared for a clean restart
        s_d.active[i]    = 1'b0; // RL1
        s_d.pos[i]       = 32'h0000_0000;
        s_d.acc[i]       = 32'h0000_0000; // RL18
        s_d.have_last[i] = 1'b0;
        have             = 1'b0;
      end else if (s_q.pos[i] == 32'h0000_0000) begin
        // period boundary: fetch the next word
        if (!qsrc) begin
          w    = s_q.value[i]; // RL9
          have = 1'b1;
        end else if (cnt != '0) begin
          w                = s_q.mem[rp]; // RL9
          rp               = rp + 1'b1;
          cnt              = cnt - 1'b1;
          have             = 1'b1;
          s_d.have_last[i] = 1'b1;
        end else if (rpt && s_q.have_last[i]) begin
          have = 1'b1; // RL6
        end else begin
          have     = 1'b0;
          rerr_set = 1'b1; // RL13
          if (s_q.active[i] && !rpt) begin
            gap_set[i] = 1'b1; // RL14
          end
        end
        if (p == 32'h0000_0000) begin
          have = 1'b0;
        end
        s_d.word[i] = w;
      end
      if (have) begin
        if (ser) begin
          // msb first, tail past the word length takes the idle level
          if (s_d.pos[i] < TPW_WORD_BITS) begin
            bitv = w[5'd31 - s_q.pos[i][4:0]]; // RL4
          end else begin
            bitv = idl; // RL7 RL20
          end
        end else if (ms) begin
          bitv = (s_q.pos[i] < w); // RL5 RL19 RL22
        end else begin
          sum = {1'b0, s_q.acc[i]} + {1'b0, w}; // RL18
          if (sum >= {1'b0, p}) begin
            bitv       = 1'b1;
            s_d.acc[i] = 32'(sum - {1'b0, p});
          end else begin
            bitv       = 1'b0;
            s_d.acc[i] = sum[31:0];
          end
        end
        // a shrunk period mid-word wraps at once instead of running on
        if (s_q.pos[i] + 32'h0000_0001 >= p) begin
          s_d.pos[i] = 32'h0000_0000; // RL19 RL20
        end else begin
          s_d.pos[i] = s_q.pos[i] + 32'h0000_0001;
        end
      end else begin
        bitv = idl; // RL7
        s_d.pos[i] = 32'h0000_0000;
      end
      s_d.active[i] = have; // RL16
      s_d.out[i]    = bitv ^ inv; // RL8
    end

    // bus write side; all writes accepted whatever the enables
    if (s_q.waddr_age != TPW_SYNC_GAP_CYCLES) begin
      s_d.waddr_age = s_q.waddr_age + 2'h1;
    end
    if (wr) begin
      s_d.last_waddr = paddr_i;
      // age then equals the cycle distance seen by the next write
      s_d.waddr_age  = 2'h1;
      // one clock here, so only same-register writes this close collide
      if (paddr_i == s_q.last_waddr &&
          s_q.waddr_age < TPW_SYNC_GAP_CYCLES) begin
        bus_sync_error_set = 1'b1; // RL15
      end
      case (paddr_i)
        TPW_OFS_CHANNEL_CONTROL: begin
          s_d.ctl = pwdata_i[15:0] & TPW_CTL_WRITE_MASK; // RL2 RL17
          if (pwdata_i[TPW_CTL_QUEUE_CLEAR]) begin
            rp  = s_q.wptr; // RL10
            cnt = '0;
          end
        end
        TPW_OFS_FLAGS: begin
          if (pwdata_i[TPW_STA_WERR]) s_d.werr = 1'b0; // RL12
          if (pwdata_i[TPW_STA_RERR]) s_d.rerr = 1'b0; // RL13
          if (pwdata_i[TPW_STA_BUS_SYNC_ERROR]) s_d.bus_sync_error = 1'b0; // RL15
          s_d.gap = s_q.gap & ~pwdata_i[TPW_STA_GAP +: 2]; // RL14
        end
        TPW_OFS_DMA_CONFIG:      s_d.dma_config = pwdata_i & TPW_DMA_WRITE_MASK;
        TPW_OFS_CHANNEL1_PERIOD: s_d.period[0] = pwdata_i;
        TPW_OFS_CHANNEL1_VALUE:  s_d.value[0]  = pwdata_i;
        TPW_OFS_CHANNEL2_PERIOD: s_d.period[1] = pwdata_i;
        TPW_OFS_CHANNEL2_VALUE:  s_d.value[1]  = pwdata_i;
        TPW_OFS_QUEUE_INPUT: begin
          // full queue drops the word; a same-cycle pop frees no room
          if (s_q.count == (PW+1)'(QUEUE_DEPTH)) begin
            werr_set = 1'b1; // RL12
          end else begin
            s_d.mem[s_q.wptr] = pwdata_i; // RL21
            s_d.wptr          = s_q.wptr + 1'b1;
            cnt               = cnt + 1'b1;
          end
        end
        default: ;
      endcase
    end
    s_d.rptr  = rp;
    s_d.count = cnt;

    // hardware set wins over a write-one clear in the same cycle
    if (werr_set) s_d.werr = 1'b1;
    if (rerr_set) s_d.rerr = 1'b1;
    if (bus_sync_error_set) s_d.bus_sync_error = 1'b1;
    s_d.gap = s_d.gap | gap_set;

    // read data captured in the setup phase, held through access
    if (psel_i && !penable_i) begin
      s_d.rdata    = pwrite_i ? 32'h0000_0000 : read_word(s_q, paddr_i);
      s_d.rerr_bus = ~mapped(paddr_i);
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_q            <= '0;
      s_q.ctl        <= TPW_RST_CONTROL[15:0];
      s_q.dma_config       <= TPW_RST_DMA_CONFIG;
      s_q.period[0]  <= TPW_RST_PERIOD; // RL20
      s_q.period[1]  <= TPW_RST_PERIOD;
      s_q.value[0]   <= TPW_RST_VALUE;
      s_q.value[1]   <= TPW_RST_VALUE;
      s_q.waddr_age  <= TPW_SYNC_GAP_CYCLES;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata_o     = s_q.rdata;
  assign pready_o     = 1'b1;
  assign pslverr_o    = psel_i & penable_i & s_q.rerr_bus;
  assign chan_out_o   = s_q.out;
  assign dma_config_o = s_q.dma_config;
endmodule
`default_nettype wire

// [src/tpw_pkg.sv]
package tpw_pkg;
  // register byte offsets
  localparam logic [7:0] TPW_OFS_CHANNEL_CONTROL  = 8'h00;
  localparam logic [7:0] TPW_OFS_FLAGS            = 8'h04;
  localparam logic [7:0] TPW_OFS_DMA_CONFIG       = 8'h08;
  localparam logic [7:0] TPW_OFS_CHANNEL1_PERIOD  = 8'h10;
  localparam logic [7:0] TPW_OFS_CHANNEL1_VALUE   = 8'h14;
  localparam logic [7:0] TPW_OFS_QUEUE_INPUT      = 8'h18;
  localparam logic [7:0] TPW_OFS_CHANNEL2_PERIOD  = 8'h20;
  localparam logic [7:0] TPW_OFS_CHANNEL2_VALUE   = 8'h24;
  // channel_control fields, channel 2 sits one stride above channel 1
  localparam int         TPW_CTL_STRIDE           = 8;
  localparam int         TPW_CTL_ENABLE           = 0;
  localparam int         TPW_CTL_SERIAL           = 1;
  localparam int         TPW_CTL_REPEAT           = 2;
  localparam int         TPW_CTL_IDLE             = 3;
  localparam int         TPW_CTL_INVERT           = 4;
  localparam int         TPW_CTL_QUEUE_SRC        = 5;
  localparam int         TPW_CTL_QUEUE_CLEAR      = 6;
  localparam int         TPW_CTL_MARK_SPACE       = 7;
  localparam logic [15:0] TPW_CTL_WRITE_MASK      = 16'hbfbf;
  // fifo_and_channel_flags fields
  localparam int         TPW_STA_FULL             = 0;
  localparam int         TPW_STA_EMPTY            = 1;
  localparam int         TPW_STA_WERR             = 2;
  localparam int         TPW_STA_RERR             = 3;
  localparam int         TPW_STA_GAP              = 4;
  localparam int         TPW_STA_BUS_SYNC_ERROR             = 8;
  localparam int         TPW_STA_ACTIVE           = 9;
  // reset values, and the dma_config write mask
  localparam logic [31:0] TPW_RST_CONTROL         = 32'h0000_0000;
  localparam logic [31:0] TPW_RST_DMA_CONFIG      = 32'h0000_0707;
  localparam logic [31:0] TPW_DMA_WRITE_MASK      = 32'h8000_ffff;
  localparam logic [31:0] TPW_RST_PERIOD          = 32'h0000_0020;
  localparam logic [31:0] TPW_RST_VALUE           = 32'h0000_0000;
  // serial word length in bits
  localparam logic [31:0] TPW_WORD_BITS           = 32'h0000_0020;
  // writes to one register closer than this many cycles collide
  localparam logic [1:0] TPW_SYNC_GAP_CYCLES      = 2'h3;
endpackage

// [verification/test_tpw_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
module test_tpw_ctrl;
  import tpw_pkg::*;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic [1:0]  chan_out_o;
  logic [31:0] dma_config_o;
  logic        clr = 1'b1;
  logic [15:0] ones1;
  logic [15:0] ones2;
  logic [31:0] rd_v;
  logic [31:0] w;
  logic [31:0] mflags = 32'h0;
  logic        err_v;
  logic [31:0] mq[$];
  logic [7:0]  ofs[9] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h20,
                          8'h24, 8'h0c};
  logic [31:0] rst[9] = '{0, 2, 32'h707, 32, 0, 0, 32, 0, 0};
  int          n_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          acc;
  always #12.5 clk_i = ~clk_i;
  tpw_ctrl i_tpw_ctrl (
    .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .chan_out_o(chan_out_o),
    .dma_config_o(dma_config_o)
  );
  tpw_load i_tpw_load (.clk_i(clk_i), .clr_i(clr), .chan_i(chan_out_o),
    .ones1_o(ones1), .ones2_o(ones2));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // entered at a falling edge; idle=0 chains the next setup directly
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic idle);
    // penable is already low here, left so by the previous call
    psel_i = 1'b1;
    pwrite_i = wr;
    paddr_i = a;
    pwdata_i = d;
    @(negedge clk_i);
    penable_i = 1'b1;
    @(posedge clk_i);
    rd_v = prdata_o;
    err_v = pslverr_o;
    @(negedge clk_i);
    penable_i = 1'b0;
    if (idle) psel_i = 1'b0;
    if (idle) @(negedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 1'b1);
    check(rd_v, e);
  endtask
  task automatic push(input logic [31:0] d);
    wr(TPW_OFS_QUEUE_INPUT, d);
    if (mq.size() < 8) mq.push_back(d);
    else mflags[2] = 1'b1;
  endtask
  function automatic logic [31:0] fifo_and_channel_flags();
    return mflags | {30'h0, mq.size() == 0, mq.size() == 8};
  endfunction
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(32'h174a));
    repeat (10) @(negedge clk_i);
    reset_i = 1'b0;
    clr = 1'b0;
    foreach (ofs[i]) rd(ofs[i], rst[i]);
    check({31'h0, err_v}, 32'h1);
    foreach (ofs[i]) if (i inside {2, 3, 4, 6, 7}) begin
      w = $urandom();
      wr(ofs[i], w);
      rd(ofs[i], i == 2 ? w & 32'h8000_ffff : w);
    end
    w = $urandom();
    wr(TPW_OFS_CHANNEL1_PERIOD, 32'd36);
    wr(TPW_OFS_CHANNEL1_VALUE, w);
    wr(TPW_OFS_CHANNEL_CONTROL, 32'h0000_000b);
    for (int k = 0; k < 36; k++) begin
      check(32'(chan_out_o[0]), k < 32 ? 32'(w[31-k]) : 32'h1);
      @(negedge clk_i);
    end
    rd(TPW_OFS_FLAGS, fifo_and_channel_flags() | 32'h200);
    rd(TPW_OFS_CHANNEL_CONTROL, 32'h0000_000b);
    wr(TPW_OFS_CHANNEL2_PERIOD, 32'd8);
    wr(TPW_OFS_CHANNEL2_VALUE, 32'd3);
    wr(TPW_OFS_CHANNEL_CONTROL, 32'h0000_9108);
    repeat (4) @(negedge clk_i);
    clr = 1'b1;
    @(negedge clk_i);
    clr = 1'b0;
    repeat (16) @(negedge clk_i);
    check(32'(ones2), 32'd10);
    check(32'(ones1), 32'd16);
    w = $urandom_range(10, 1);
    wr(TPW_OFS_CHANNEL1_PERIOD, 32'd10);
    wr(TPW_OFS_CHANNEL1_VALUE, w);
    wr(TPW_OFS_CHANNEL_CONTROL, 32'h0000_0001);
    acc = 0;
    for (int k = 0; k < 20; k++) begin
      acc += int'(w);
      check(32'(chan_out_o[0]), acc >= 10 ? 32'h1 : 32'h0);
      if (acc >= 10) acc -= 10;
      @(negedge clk_i);
    end
    wr(TPW_OFS_CHANNEL_CONTROL, 32'h0);
    wr(TPW_OFS_CHANNEL1_VALUE, 32'h0);
    wr(TPW_OFS_CHANNEL_CONTROL, 32'h0000_0001);
    repeat (5) @(negedge clk_i);
    wr(TPW_OFS_CHANNEL_CONTROL, 32'h0);
    repeat (9) push($urandom());
    rd(TPW_OFS_FLAGS, fifo_and_channel_flags());
    wr(TPW_OFS_FLAGS, 32'h4);
    mflags[2] = 1'b0;
    rd(TPW_OFS_FLAGS, fifo_and_channel_flags());
    wr(TPW_OFS_CHANNEL_CONTROL, 32'h40);
    mq.delete();
    rd(TPW_OFS_FLAGS, fifo_and_channel_flags());
    w = $urandom();
    push(w);
    wr(TPW_OFS_CHANNEL1_PERIOD, 32'd32);
    wr(TPW_OFS_CHANNEL_CONTROL, 32'h23);
    void'(mq.pop_front());
    for (int k = 0; k < 32; k++) begin
      check(32'(chan_out_o[0]), 32'(w[31-k]));
      @(negedge clk_i);
    end
    repeat (8) @(negedge clk_i);
    mflags = 32'h18;
    rd(TPW_OFS_FLAGS, fifo_and_channel_flags());
    wr(TPW_OFS_CHANNEL_CONTROL, 32'h0);
    bus(1'b1, TPW_OFS_DMA_CONFIG, 32'h1, 1'b0);
    bus(1'b1, TPW_OFS_DMA_CONFIG, 32'h2, 1'b1);
    check(dma_config_o, 32'h0000_0002);
    mflags[8] = 1'b1;
    rd(TPW_OFS_FLAGS, fifo_and_channel_flags());
    wr(TPW_OFS_FLAGS, 32'h11c);
    mflags = 32'h0;
    rd(TPW_OFS_FLAGS, fifo_and_channel_flags());
    wrap_up();
  end
endmodule
bind tpw_ctrl tpw_ctrl_chk #(.QUEUE_DEPTH(QUEUE_DEPTH)) i_tpw_ctrl_chk (
  .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .chan_out_o(chan_out_o),
  .dma_config_o(dma_config_o)
);
`default_nettype wire

// [verification/tpw_ctrl_props.sv]
`timescale 1ns/100ps
`default_nettype none
module tpw_ctrl_chk
  import tpw_pkg::*;
#(
  parameter int QUEUE_DEPTH = 8
) (
  // clock, reset and bus
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [31:0] prdata_o,
  input  wire logic        pready_o,
  input  wire logic        pslverr_o,
  // outputs
  input  wire logic [1:0]  chan_out_o,
  input  wire logic [31:0] dma_config_o
);
  logic [15:0] ctl_q;
  logic        vz_q;
  logic        fresh_q;
  logic [1:0]  quiet_q;
  logic        wr;
  logic        rd;
  assign wr = psel_i & penable_i & pwrite_i;
  assign rd = psel_i & penable_i & !pwrite_i;
  // shadow of software writes; outputs lag them by two edges
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctl_q   <= 16'h0000;
      vz_q    <= 1'b1;
      fresh_q <= 1'b0;
      quiet_q <= 2'h0;
    end else begin
      if (wr && paddr_i == TPW_OFS_CHANNEL_CONTROL) ctl_q <= pwdata_i[15:0];
      if (wr && paddr_i == TPW_OFS_CHANNEL1_VALUE) vz_q <= pwdata_i == 32'h0;
      // the word reloads only at a period boundary and the accumulator
      // survives value changes, so only a fresh enable is predictable
      if (wr && paddr_i == TPW_OFS_CHANNEL_CONTROL) begin
        fresh_q <= pwdata_i[0] & !ctl_q[0] & vz_q;
      end
      if (wr && paddr_i == TPW_OFS_CHANNEL1_VALUE && pwdata_i != 32'h0) begin
        fresh_q <= 1'b0;
      end
      if (wr) quiet_q <= 2'h0;
      else if (quiet_q != 2'h3) quiet_q <= quiet_q + 2'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_clear_zero;
    rd && paddr_i == TPW_OFS_CHANNEL_CONTROL |-> !prdata_o[6];
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear bit set");
  property p_reserved;
    rd && paddr_i == TPW_OFS_CHANNEL_CONTROL |-> prdata_o[31:14] == 18'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits");
  property p_full_empty;
    psel_i && !penable_i && !pwrite_i && paddr_i == TPW_OFS_FLAGS
      ##1 penable_i |-> !(prdata_o[0] && prdata_o[1]);
  endproperty
  a_full_empty: assert property (p_full_empty) else $error("full and empty");
  property p_idle1;
    quiet_q == 2'h3 && !ctl_q[0] |-> chan_out_o[0] == (ctl_q[3] ^ ctl_q[4]);
  endproperty
  a_idle1: assert property (p_idle1) else $error("ch1 idle level");
  property p_idle2;
    quiet_q == 2'h3 && !ctl_q[8] |-> chan_out_o[1] == (ctl_q[11] ^ ctl_q[12]);
  endproperty
  a_idle2: assert property (p_idle2) else $error("ch2 idle level");
  property p_spread_zero;
    quiet_q == 2'h3 && ctl_q[0] && ctl_q[7:5] == 3'h0 && fresh_q && vz_q &&
      ctl_q[3:1] == 3'h0 |-> chan_out_o[0] == ctl_q[4];
  endproperty
  a_spread_zero: assert property (p_spread_zero) else $error("spread");
  property p_active_off;
    (quiet_q == 2'h3 && !ctl_q[0] && !ctl_q[8]) [*2] ##0
      (rd && paddr_i == TPW_OFS_FLAGS) |-> prdata_o[10:9] == 2'b00;
  endproperty
  a_active_off: assert property (p_active_off) else $error("active off");
  property p_active_on;
    (quiet_q == 2'h3 && ctl_q[0] && ctl_q[1] && !ctl_q[5]) [*2] ##0
      (rd && paddr_i == TPW_OFS_FLAGS) |-> prdata_o[9];
  endproperty
  a_active_on: assert property (p_active_on) else $error("active on");
  property p_ready;
    psel_i && penable_i |-> pready_o;
  endproperty
  a_ready: assert property (p_ready) else $error("not ready");
  property p_dma_store;
    wr && paddr_i == TPW_OFS_DMA_CONFIG
      |=> dma_config_o == ($past(pwdata_i) & TPW_DMA_WRITE_MASK);
  endproperty
  a_dma_store: assert property (p_dma_store) else $error("dma config");
endmodule
`default_nettype wire

// [verification/tpw_load.sv]
`timescale 1ns/100ps
`default_nettype none
module tpw_load (
  // load side
  input  wire logic       clk_i,
  input  wire logic       clr_i,
  input  wire logic [1:0] chan_i,
  // high cycles seen, as an averaging filter would
  output logic [15:0]     ones1_o,
  output logic [15:0]     ones2_o
);
  // counting over a whole window makes the result phase independent
  always @(posedge clk_i) begin
    ones1_o <= clr_i ? 16'h0 : ones1_o + 16'(chan_i[0]);
    ones2_o <= clr_i ? 16'h0 : ones2_o + 16'(chan_i[1]);
  end
endmodule
`default_nettype wire
